// ### mcr_pkg.sv
// result-status package for the monotonic counter unit: opcodes, lengths, codes, types.
// assumes importers in mcr_core, mcr_host_model and mcr_core_tb; the link and core clocks are unrelated.
package mcr_pkg;

   // ****************************************************************
   // opcodes, command types and lengths
   // ****************************************************************
   localparam logic [7:0] AUTH_OPC  = 8'hC1;   // plain default, not a real code
   localparam logic [7:0] READ_OPC  = 8'hC2;   // plain default, not a real code
   localparam logic [7:0] CT_ROOT   = 8'h00;
   localparam logic [7:0] CT_HKEY   = 8'h01;
   localparam logic [7:0] CT_INC    = 8'h02;
   localparam logic [7:0] CT_REQ    = 8'h03;
   localparam logic [7:0] NUM_CTR   = 8'h04;
   localparam int         PAY_BYTES = 63;
   localparam logic [6:0] PAY_LAST  = 7'h3F;
   localparam logic [6:0] CNT_SAT   = 7'h7F;
   localparam logic [6:0] LEN_ROOT  = 7'h3F;   // 63 bytes after the opcode
   localparam logic [6:0] LEN_HKEY  = 7'h27;   // 39
   localparam logic [6:0] LEN_INC   = 7'h27;   // 39
   localparam logic [6:0] LEN_REQ   = 7'h2F;   // 47
   localparam int         KEY_BYTE0 = 3;
   localparam int         SIG_BYTE0 = 35;
   localparam int         SIG_BITS  = 224;
   localparam logic [2:0] BIT_LAST  = 3'h7;    // also the last of the 8 dummy clocks
   localparam logic [255:0] KEY_ONES = {256{1'b1}};

   // ****************************************************************
   // result status codes and bit positions
   // ****************************************************************
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [7:0] ST_OK    = 8'h80;
   localparam logic [7:0] ST_BUSY  = 8'h01;
   localparam logic [7:0] E_CMD    = 8'h02;
   localparam logic [7:0] E_AUTH   = 8'h04;
   localparam logic [7:0] E_UNINIT = 8'h08;
   localparam logic [7:0] E_DATA   = 8'h10;
   localparam logic [7:0] E_FATAL  = 8'h20;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      L_OPC  = 3'b000, L_PAY = 3'b001, L_DUM = 3'b010, L_STAT = 3'b011, L_IGN = 3'b100
   } mcr_lmode_e;
   typedef enum logic [2:0] {
      C_IDLE = 3'b000, C_WAIT = 3'b001, C_CHECK = 3'b010, C_HMAC = 3'b011, C_EXT = 3'b100
   } mcr_cstate_e;
   typedef logic [PAY_BYTES-1:0][7:0] mcr_pay_t;

   typedef struct packed {
      logic         req;
      logic [255:0] key;
      logic [31:0]  msg;
   } mcr_hreq_s;
   typedef struct packed {
      logic         done;
      logic [255:0] digest;
   } mcr_hrsp_s;
   typedef struct packed {
      logic       req;
      logic [7:0] cmd;
      logic [7:0] idx;
      mcr_pay_t   pay;
   } mcr_ereq_s;
   typedef struct packed {
      logic done;
      logic sig_bad;
      logic ctr_uninit;
      logic key_uninit;
      logic data_bad;
   } mcr_ersp_s;
endpackage : mcr_pkg

// ### mcr_core.sv
// serial front end and result-status logic of the monotonic counter unit.
// assumes an external hmac engine and counter store answering on clock; spi mode 0 link.
// What this block does
// - status reads all zeros apart from fatal bit 5 before any authenticated command since power-up.
// - error-free command types 00 to 03 end with status exactly 80h.
// - busy bit 0 set while any command type executes, cleared at finish.
// - type 00 sets bit 1 on overwrite, bad counter index or bad signature.
// - type 01 sets bit 1 when the addressed counter is uninitialised.
// - bit 2 on bad signature, bad index, bad command type or wrong size.
// - types 02 and 03 set bit 3 on uninitialised key or counter.
// - type 02 sets bit 4 when supplied counter data mismatches.
// - bit 5 flags fatal loss of a valid counter.
// - status bits 4 to 0 stay unchanged until the full auth opcode byte is in.
// - frames over 16 clocks report the correct error type.
// - an error-free root write loads the indexed root key.
// - short signature equals low 224 bits of the hmac result.
// - root hmac message is opcode, type, index, reserved keyed by received key.
// - a non all-ones root key may be written only once per counter.
// - an all-ones root key is temporary and keeps the one write.
// - any errored root transaction is not executed and posts its error.
// - busy bit 0 is driven; host ignores it per its capability bit.
// - type 00 with wrong payload length sets bit 2.
// - result read opcode is followed by 8 dummy clocks, then the status.
// - fields travel most significant byte and bit first.
`timescale 1ns/1ps
`default_nettype none
module mcr_core (
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  wire logic               sclk,
   input  wire logic               cs_n,
   input  wire logic               mosi,
   output logic                    miso,
   output logic                    miso_oe,
   input  wire logic               ctr_fatal,
   output mcr_pkg::mcr_hreq_s      hmac_req,
   input  wire mcr_pkg::mcr_hrsp_s hmac_rsp,
   output mcr_pkg::mcr_ereq_s      ext_req,
   input  wire mcr_pkg::mcr_ersp_s ext_rsp,
   output logic [7:0]              counter_result_status
);
   import mcr_pkg::*;

   // ****************************************************************
   // state structs
   // ****************************************************************
   typedef struct packed {
      mcr_lmode_e mode;
      logic [2:0] bitcnt;
      logic [6:0] sh;
      logic       auth;
   } mcr_link_s;
   typedef struct packed {
      mcr_pay_t   pay;
      logic [6:0] cnt;
   } mcr_data_s;
   typedef struct packed {
      logic       oe;
      logic [7:0] sh;
   } mcr_out_s;
   typedef struct packed {
      logic [2:0]        cs_s;
      logic [2:0]        au_s;
      mcr_cstate_e       state;
      logic [7:0]        status;
      logic [7:0]        pub;
      mcr_pay_t          cpay;
      logic [6:0]        ccnt;
      logic              ovw;
      logic [3:0][255:0] root_key;
      logic [3:0]        root_wr;
      mcr_hreq_s         hq;
      mcr_ereq_s         eq;
   } mcr_core_s;

   mcr_link_s lnk_ff, nxt_lnk;
   mcr_data_s dat_ff, nxt_dat;
   mcr_out_s  out_ff, nxt_out;
   mcr_core_s core_ff, nxt_core;
   logic      byte_done;
   logic [7:0] rx_byte;
   logic      cs_idle;
   logic      au_rise;
   logic      sig_ok;
   logic      commit;
   logic [1:0] cix;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [255:0] key_of(input mcr_pay_t p);
      logic [255:0] k;
      k = '0;
      for (int i = 0; i < 32; i++) begin
         k[255-8*i -: 8] = p[KEY_BYTE0+i];   // most significant byte first
      end
      return k;
   endfunction : key_of

   function automatic logic [SIG_BITS-1:0] sig_of(input mcr_pay_t p);
      logic [SIG_BITS-1:0] s;
      s = '0;
      for (int i = 0; i < 28; i++) begin
         s[SIG_BITS-1-8*i -: 8] = p[SIG_BYTE0+i];
      end
      return s;
   endfunction : sig_of

   // errors win over success; fatal joins every completion
   function automatic logic [7:0] finish(input logic [7:0] e, input logic fatal);
      logic [7:0] f;
      f = e | (fatal ? E_FATAL : 8'h00);
      return (f == 8'h00) ? ST_OK : f;
   endfunction : finish

   // ****************************************************************
   // link side, sclk edges; all but the payload store cleared whenever the frame ends
   // ****************************************************************
   assign byte_done = (lnk_ff.bitcnt == BIT_LAST);
   assign rx_byte   = {lnk_ff.sh, mosi};   // msb first

   always_comb begin
      nxt_lnk        = lnk_ff;
      nxt_lnk.bitcnt = lnk_ff.bitcnt + 3'h1;
      nxt_lnk.sh     = {lnk_ff.sh[5:0], mosi};
      case (lnk_ff.mode)
         L_OPC: begin
            if (byte_done) begin
               if (rx_byte == AUTH_OPC) begin
                  nxt_lnk.mode = L_PAY;
                  nxt_lnk.auth = 1'b1;   // only after all 8 opcode bits
               end else if (rx_byte == READ_OPC) begin
                  nxt_lnk.mode = L_DUM;
               end else begin
                  nxt_lnk.mode = L_IGN;
               end
            end
         end
         L_DUM: begin
            if (byte_done) begin
               nxt_lnk.mode = L_STAT;   // 8 dummy clocks passed
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         lnk_ff <= '{mode: L_OPC, bitcnt: 3'h0, sh: 7'h00, auth: 1'b0};
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // payload store survives the frame end so the core can copy it afterwards
   always_comb begin
      nxt_dat = dat_ff;
      if (lnk_ff.mode == L_OPC && byte_done && rx_byte == AUTH_OPC) begin
         nxt_dat.cnt = 7'h00;
      end
      if (lnk_ff.mode == L_PAY && byte_done) begin
         if (dat_ff.cnt < PAY_LAST) begin
            nxt_dat.pay[dat_ff.cnt[5:0]] = rx_byte;   // type byte lands at index 0
         end
         if (dat_ff.cnt != CNT_SAT) begin
            nxt_dat.cnt = dat_ff.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge sclk) begin
      dat_ff <= nxt_dat;
   end

   // status shifts out on falling edges; pub is frozen while cs_n is low
   always_comb begin
      nxt_out = out_ff;
      if (lnk_ff.mode == L_STAT && !out_ff.oe) begin
         nxt_out.oe = 1'b1;
         nxt_out.sh = core_ff.pub;
      end else if (out_ff.oe) begin
         nxt_out.sh = {out_ff.sh[6:0], 1'b0};
      end
   end

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         out_ff <= '{oe: 1'b0, sh: 8'h00};
      end else begin
         out_ff <= nxt_out;
      end
   end

   assign miso    = out_ff.sh[7];
   assign miso_oe = out_ff.oe;

   // ****************************************************************
   // core side, posedge clock
   // ****************************************************************
   // idle needs the second and third cs_n stages both high; an auth rise is second high, third low
   assign cs_idle = core_ff.cs_s[1] & core_ff.cs_s[2];
   assign au_rise = core_ff.au_s[1] & ~core_ff.au_s[2];
   assign cix     = core_ff.cpay[1][1:0];
   assign sig_ok  = (hmac_rsp.digest[SIG_BITS-1:0] == sig_of(core_ff.cpay));
   assign commit  = (core_ff.state == C_HMAC) && hmac_rsp.done && sig_ok && !core_ff.ovw;

   always_comb begin
      logic [7:0] e;
      e              = 8'h00;
      nxt_core       = core_ff;
      nxt_core.cs_s  = {core_ff.cs_s[1:0], cs_n};
      nxt_core.au_s  = {core_ff.au_s[1:0], lnk_ff.auth};
      nxt_core.hq.req = 1'b0;
      nxt_core.eq.req = 1'b0;
      // publish only between frames so the link reads a still word
      if (cs_idle) begin
         nxt_core.pub = core_ff.status;
      end
      case (core_ff.state)
         C_IDLE: begin
            if (au_rise) begin
               nxt_core.status = ST_BUSY;
               nxt_core.state  = C_WAIT;
            end else if (ctr_fatal) begin
               nxt_core.status = (core_ff.status | E_FATAL) & ~ST_OK;
            end
         end
         C_WAIT: begin
            if (cs_idle) begin
               nxt_core.cpay  = dat_ff.pay;
               nxt_core.ccnt  = dat_ff.cnt;
               nxt_core.state = C_CHECK;
            end
         end
         C_CHECK: begin
            nxt_core.state = C_IDLE;
            if (core_ff.cpay[0] == CT_ROOT) begin
               if (core_ff.ccnt != LEN_ROOT) begin
                  e = E_AUTH;
               end else if (core_ff.cpay[1] >= NUM_CTR) begin
                  e = E_CMD | E_AUTH;
               end else begin
                  // written-once check needs no hmac, signature still checked
                  nxt_core.ovw        = core_ff.root_wr[cix];
                  nxt_core.hq.req     = 1'b1;
                  nxt_core.hq.key     = key_of(core_ff.cpay);
                  nxt_core.hq.msg     = {AUTH_OPC, core_ff.cpay[0], core_ff.cpay[1],
                                         core_ff.cpay[2]};
                  nxt_core.state      = C_HMAC;
               end
            end else if (core_ff.cpay[0] <= CT_REQ) begin
               if ((core_ff.cpay[0] == CT_HKEY && core_ff.ccnt != LEN_HKEY)
                   || (core_ff.cpay[0] == CT_INC && core_ff.ccnt != LEN_INC)
                   || (core_ff.cpay[0] == CT_REQ && core_ff.ccnt != LEN_REQ)
                   || core_ff.cpay[1] >= NUM_CTR) begin
                  e = E_AUTH;
               end else begin
                  nxt_core.eq.req = 1'b1;
                  nxt_core.eq.cmd = core_ff.cpay[0];
                  nxt_core.eq.idx = core_ff.cpay[1];
                  nxt_core.eq.pay = core_ff.cpay;
                  nxt_core.state  = C_EXT;
               end
            end else begin
               e = E_AUTH;   // type out of range
            end
            if (nxt_core.state == C_IDLE) begin
               nxt_core.status = finish(e, ctr_fatal);
            end
         end
         C_HMAC: begin
            if (hmac_rsp.done) begin
               if (!sig_ok) begin
                  e = E_CMD | E_AUTH;
               end
               if (core_ff.ovw) begin
                  e = e | E_CMD;   // errored writes are dropped
               end
               if (commit) begin
                  nxt_core.root_key[cix] = key_of(core_ff.cpay);
                  if (key_of(core_ff.cpay) != KEY_ONES) begin
                     nxt_core.root_wr[cix] = 1'b1;   // all-ones keeps the write
                  end
               end
               nxt_core.status = finish(e, ctr_fatal);
               nxt_core.state  = C_IDLE;
            end
         end
         C_EXT: begin
            if (ext_rsp.done) begin
               if (ext_rsp.sig_bad) begin
                  e = E_AUTH;
               end
               if (core_ff.eq.cmd == CT_HKEY && ext_rsp.ctr_uninit) begin
                  e = e | E_CMD;
               end
               if (core_ff.eq.cmd != CT_HKEY && (ext_rsp.ctr_uninit || ext_rsp.key_uninit)) begin
                  e = e | E_UNINIT;
               end
               if (core_ff.eq.cmd == CT_INC && ext_rsp.data_bad) begin
                  e = e | E_DATA;
               end
               nxt_core.status = finish(e, ctr_fatal);
               nxt_core.state  = C_IDLE;
            end
         end
         default: begin
            nxt_core.state = C_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         core_ff        <= '0;
         core_ff.cs_s   <= 3'h7;
         core_ff.state  <= C_IDLE;
         core_ff.status <= ST_RESET;
         core_ff.pub    <= ST_RESET;
      end else begin
         core_ff <= nxt_core;
      end
   end

   assign hmac_req              = core_ff.hq;
   assign ext_req               = core_ff.eq;
   assign counter_result_status = core_ff.status;

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic seen_ff;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         seen_ff <= 1'b0;
      end else if (au_rise) begin
         seen_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_power_on_zero: assert property (
      !seen_ff |-> core_ff.status[4:0] == 5'h00 && !core_ff.status[7])
      else $error("status not zero before first command");
   a_success_exact: assert property (
      core_ff.status[7] |-> core_ff.status[6:0] == 7'h00)
      else $error("success code mixed with other bits");
   a_busy_on_opcode: assert property (
      core_ff.state == C_IDLE && au_rise |=> core_ff.status == ST_BUSY)
      else $error("opcode did not clear status to busy");
   a_busy_while_run: assert property (
      core_ff.state != C_IDLE |-> core_ff.status[0])
      else $error("busy bit low during execution");
   a_busy_clear_done: assert property (
      core_ff.state != C_IDLE ##1 core_ff.state == C_IDLE |-> !core_ff.status[0])
      else $error("busy bit left set after completion");
   a_root_size_err: assert property (
      core_ff.state == C_CHECK && core_ff.cpay[0] == CT_ROOT && core_ff.ccnt != LEN_ROOT
      |=> core_ff.status[2] && !core_ff.status[7])
      else $error("wrong root payload size not flagged");
   a_bad_type_err: assert property (
      core_ff.state == C_CHECK && core_ff.cpay[0] > CT_REQ
      |=> (core_ff.status & ~E_FATAL) == E_AUTH)
      else $error("out of range type not flagged");
   a_status_hold: assert property (
      core_ff.state == C_IDLE && !au_rise |=> $stable(core_ff.status[4:0]))
      else $error("status moved without an opcode");
   a_root_load: assert property (
      commit |=> core_ff.root_key[$past(cix)] == key_of(core_ff.cpay))
      else $error("root key not loaded on clean write");
   a_write_once: assert property (
      ($past(core_ff.root_wr) & ~core_ff.root_wr) == 4'h0)
      else $error("root write-once flag fell");
   a_temp_key: assert property (
      commit && key_of(core_ff.cpay) == KEY_ONES |=> $stable(core_ff.root_wr))
      else $error("temporary key consumed the single write");
   a_hmac_msg: assert property (
      core_ff.hq.req |-> core_ff.hq.msg[31:24] == AUTH_OPC && core_ff.hq.msg[23:16] == CT_ROOT)
      else $error("hmac message malformed");
   a_no_exec_err: assert property (
      core_ff.state == C_HMAC && hmac_rsp.done && !sig_ok
      |=> $stable(core_ff.root_wr) && core_ff.status[2:1] == 2'h3)
      else $error("errored root write executed");

   c_root_ok: cover property (commit ##1 core_ff.status == ST_OK);
   c_root_ovw: cover property (core_ff.state == C_HMAC && hmac_rsp.done && core_ff.ovw);
   c_ext_done: cover property (core_ff.state == C_EXT && ext_rsp.done);
   c_bad_type: cover property (core_ff.state == C_CHECK && core_ff.cpay[0] > CT_REQ);
endmodule : mcr_core
`default_nettype wire

// ### mcr_host_model.sv
// spi host model for the counter status block: single-lane mode 0 frames.
// assumes the device samples mosi on sclk rise and drives miso on sclk fall.
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   import mcr_pkg::*;
   logic oe_seen;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      oe_seen = 1'b0;
   end
   // msb first; sclk only moves inside a frame
   task automatic shift(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #32 sclk = 1'b1;
         r[i] = miso;
         oe_seen = oe_seen & miso_oe;
         #32 sclk = 1'b0;
      end
   endtask : shift
   // released mosi shows the inverse of its last bit, so stale data cannot pass
   task automatic close;
      #32 cs_n = 1'b1;
      mosi = ~mosi;
   endtask : close
   // opcode, then type, index, reserved, key and signature
   task automatic send(input logic [7:0] q[$]);
      logic [7:0] r;
      #5.3 cs_n = 1'b0;
      foreach (q[k]) shift(q[k], r);
      close();
   endtask : send
   // opcode, 8 dummy clocks, then the status byte; miso_oe is sampled over it
   task automatic read_status(output logic [7:0] v, output logic oe);
      logic [7:0] r;
      #5.3 cs_n = 1'b0;
      shift(READ_OPC, r);
      shift(8'h00, r);
      oe_seen = 1'b1;
      shift(8'h00, v);
      oe = oe_seen;
      close();
      #80;
   endtask : read_status
endmodule : mcr_host_model
`default_nettype wire

// ### mcr_core_tb.sv
// self-checking bench for mcr_core with spi host model and engine stubs.
// assumes mcr_host_model on the link and a 250 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module mcr_core_tb;
   import mcr_pkg::*;
   localparam logic [223:0] SIG = {28{8'h5A}};
   localparam logic [255:0] KEY = {8{32'h1234ABCD}};
   logic         clock;
   logic         sys_rst;
   logic         sclk;
   logic         cs_n;
   logic         mosi;
   logic         miso;
   logic         miso_oe;
   logic         ctr_fatal;
   mcr_hreq_s    hmac_req;
   mcr_hrsp_s    hmac_rsp;
   mcr_ereq_s    ext_req;
   mcr_ersp_s    ext_rsp;
   logic [7:0]   counter_result_status;
   logic         sig_ok;
   logic [3:0]   e_flags;
   logic [31:0]  last_msg;
   logic [255:0] last_key;
   logic [7:0]   last_cmd;
   logic [7:0]   last_idx;
   int           bad_count;
   int           checks;

   mcr_core u_dut (.clock(clock), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe), .ctr_fatal(ctr_fatal), .hmac_req(hmac_req),
      .hmac_rsp(hmac_rsp), .ext_req(ext_req), .ext_rsp(ext_rsp),
      .counter_result_status(counter_result_status));
   mcr_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

   always #2 clock = ~clock;

   // hmac stub: low 224 digest bits carry the signature when it should match
   always begin
      @(posedge clock iff hmac_req.req === 1'b1);
      last_msg = hmac_req.msg;
      last_key = hmac_req.key;
      repeat (3) @(negedge clock);
      hmac_rsp.digest = {32'h0, sig_ok ? SIG : ~SIG};
      hmac_rsp.done = 1'b1;
      @(negedge clock);
      hmac_rsp.done = 1'b0;
   end
   always begin
      @(posedge clock iff ext_req.req === 1'b1);
      last_cmd = ext_req.cmd;
      last_idx = ext_req.idx;
      repeat (5) @(negedge clock);
      ext_rsp = {1'b1, e_flags};
      @(negedge clock);
      ext_rsp = '0;
   end

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte
   task automatic chk_vec(input string what, input logic [255:0] exp, input logic [255:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_vec
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   // one authenticated frame of nb bytes after the opcode, then poll and read back
   task automatic do_cmd(input logic [7:0] ct, input logic [7:0] idx, input logic [255:0] key,
                         input int nb, input logic [7:0] exp);
      logic [7:0] q[$];
      logic [7:0] st;
      logic       oe;
      int         n;
      q = {AUTH_OPC, ct, idx, 8'h00};
      for (int i = 31; i >= 0; i--) q.push_back(key[i*8 +: 8]);
      for (int i = 27; i >= 0; i--) q.push_back(SIG[i*8 +: 8]);
      while (q.size() > nb + 1) void'(q.pop_back());
      u_host.send(q);
      chk_byte("busy", ST_BUSY, counter_result_status & ~E_FATAL);
      n = 0;
      while (counter_result_status[0] !== 1'b0 && n < 300) begin
         @(negedge clock);
         n++;
      end
      if (n == 300) begin
         bad_count++;
         finish_test();
      end
      repeat (8) @(negedge clock);
      u_host.read_status(st, oe);
      chk_byte("status", exp, counter_result_status);
      chk_byte("status read", exp, st);
      chk_byte("miso_oe", 8'h01, {7'h0, oe});
   endtask : do_cmd

   task automatic t_power_on;
      logic [7:0] st;
      logic       oe;
      logic [7:0] q[$];
      // a foreign opcode with the auth code as its second byte must leave status alone
      q = {8'h3C, AUTH_OPC};
      u_host.send(q);
      repeat (8) @(negedge clock);
      u_host.read_status(st, oe);
      chk_byte("power-on oe", 8'h01, {7'h0, oe});
      chk_byte("power-on read", ST_RESET, st);
      chk_byte("power-on port", ST_RESET, counter_result_status);
      $display("test power_on done");
   endtask : t_power_on
   task automatic t_root_errors;
      do_cmd(CT_ROOT, 8'h01, KEY, 20, E_AUTH);
      do_cmd(CT_ROOT, NUM_CTR, KEY, 63, 8'h06);
      sig_ok = 1'b0;
      do_cmd(CT_ROOT, 8'h01, KEY, 63, 8'h06);
      sig_ok = 1'b1;
      $display("test root_errors done");
   endtask : t_root_errors
   task automatic t_root_write;
      do_cmd(CT_ROOT, 8'h01, KEY_ONES, 63, ST_OK);
      chk_vec("hmac msg", {224'h0, AUTH_OPC, CT_ROOT, 8'h01, 8'h00}, {224'h0, last_msg});
      do_cmd(CT_ROOT, 8'h01, KEY, 63, ST_OK);
      chk_vec("root key", KEY, last_key);
      do_cmd(CT_ROOT, 8'h01, KEY, 63, E_CMD);
      $display("test root_write done");
   endtask : t_root_write
   task automatic t_ext_types;
      logic [7:0] ct [6] = '{CT_HKEY, CT_INC, CT_REQ, CT_HKEY, CT_REQ, 8'h05};
      int         nb [6] = '{39, 39, 47, 39, 47, 39};
      logic [3:0] fl [6] = '{4'h4, 4'h1, 4'h2, 4'h8, 4'h0, 4'h0};
      logic [7:0] ex [6] = '{E_CMD, E_DATA, E_UNINIT, E_AUTH, ST_OK, E_AUTH};
      for (int i = 0; i < 6; i++) begin
         e_flags = fl[i];
         do_cmd(ct[i], 8'h02, KEY, nb[i], ex[i]);
         if (i < 5) chk_byte("engine cmd", ct[i], last_cmd);
         if (i < 5) chk_byte("engine index", 8'h02, last_idx);
      end
      $display("test ext_types done");
   endtask : t_ext_types
   task automatic t_fatal;
      e_flags = 4'h0;
      @(negedge clock);
      ctr_fatal = 1'b1;
      repeat (2) @(negedge clock);
      chk_byte("idle fatal", E_FATAL | E_AUTH, counter_result_status);
      do_cmd(CT_HKEY, 8'h03, KEY, 39, E_FATAL);
      @(negedge clock);
      ctr_fatal = 1'b0;
      $display("test fatal done");
   endtask : t_fatal

   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      ctr_fatal = 1'b0;
      hmac_rsp = '0;
      ext_rsp = '0;
      sig_ok = 1'b1;
      e_flags = 4'h0;
      bad_count = 0;
      checks = 0;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      repeat (5) @(negedge clock);
      t_power_on();
      t_root_errors();
      t_root_write();
      t_ext_types();
      t_fatal();
      finish_test();
   end
   // hang guard: counts as a mismatch
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end
endmodule : mcr_core_tb
`default_nettype wire
